/* hw/epsvb_regs.svh */
// register offsets, field positions and reset values of the exception pend block
`ifndef EPSVB_REGS_SVH
`define EPSVB_REGS_SVH
`define EPSVB_ADDR_W 32
`define EPSVB_ICS_ADDR 32'hE000ED04
`define EPSVB_VTO_ADDR 32'hE000ED08
`define EPSVB_ICS_RESET 32'h00000000
`define EPSVB_VTO_RESET 32'h00000000
`define EPSVB_NMI_SET_BIT 31
`define EPSVB_DS_SET_BIT 28
`define EPSVB_DS_CLR_BIT 27
`define EPSVB_ST_SET_BIT 26
`define EPSVB_ST_CLR_BIT 25
`define EPSVB_DEBUG_BIT 23
`define EPSVB_IRQ_PEND_BIT 22
`define EPSVB_PEND_HI 20
`define EPSVB_PEND_LO 12
`define EPSVB_NOPRE_BIT 11
`define EPSVB_ACT_HI 8
`define EPSVB_ACT_LO 0
`define EPSVB_TBL_HI 31
`define EPSVB_TBL_LO 9
`define EPSVB_EXT_OFFSET 9'h010
`define EPSVB_RESP_OKAY 2'h0
`define EPSVB_RESP_SLVERR 2'h2
`endif

/* hw/epsvb_pkg.sv */
// types of the exception pend block
package epsvb_pkg;
    typedef struct packed {
        logic [8:0] active_exception_number;
        logic no_preempted_active;
        logic [8:0] highest_pending_number;
        logic interrupt_pending_flag;
        logic debug_state;
    } epsvb_core_type;
    typedef struct packed {
        logic nmi_pend;
        logic ds_pend;
        logic st_pend;
    } epsvb_pend_type;
endpackage

/* hw/epsvb_top.sv */
// exception pend state and vector base registers with axi4-lite slave
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "epsvb_regs.svh"
// Behaviour
// - writing 1 to bit 31 pends the nonmaskable interrupt; reads show it
// - nonmaskable handler entry clears that pending bit
// - during handler, bit reads 1 only if input reasserted or software writes 1 to bit 31
// - writing 1 to bit 28 pends deferred service; reads show state
// - deferred service pends only by software write
// - writing 1 to bit 27 clears deferred service pending
// - writing 1 to bit 26 pends system tick; reads show state
// - writing 1 to bit 25 clears system tick pending
// - bit 23 reads zero outside debug state
// - bit 22 shows any interrupt pending, excluding nonmaskable and faults
// - bits 20:12 give highest pending enabled exception, or zero
// - highest pending honours base and fault masks, not primary mask
// - bit 11 reads 0 while preempted active exceptions remain
// - bits 8:0 give active exception number, zero in thread mode
// - external interrupt numbers are index plus 16
// - active field equals program status bits 8:0
// - vector base is an offset from address zero
// - offset register bits 31:9 give table offset bits 31:9
// - low nine bits of the effective offset are zero
// - registers at 0xE000ED04 and 0xE000ED08, privileged, reset zero
module epsvb_top (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [31:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [31:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // core status
    input wire epsvb_pkg::epsvb_core_type core_status,
    input wire logic nmi_request,
    input wire logic system_tick_exception_request,
    input wire logic nmi_handler_entry,
    input wire logic ds_handler_entry,
    input wire logic st_handler_entry,
    // pending state and vector base to core
    output epsvb_pkg::epsvb_pend_type pend_state,
    output logic [31:0] vector_table_base
);

    ////////////////////////////////////////////////////////////////////////
    // write channel capture
    logic aw_held_r;
    logic w_held_r;
    logic [31:0] awaddr_r;
    logic awpriv_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic wr_go;
    logic wr_ics;
    logic wr_vto;
    logic [31:0] wr_data;

    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready = !w_held_r && !bvalid_r;
    assign wr_go = aw_held_r && w_held_r && !bvalid_r;
    assign wr_ics = wr_go && awpriv_r && awaddr_r == `EPSVB_ICS_ADDR;
    assign wr_vto = wr_go && awpriv_r && awaddr_r == `EPSVB_VTO_ADDR;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            awaddr_r <= 32'h00000000;
            awpriv_r <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r <= {s_axi_awaddr[31:2], 2'h0};
            awpriv_r <= s_axi_awprot[0];
        end else if (wr_go) begin
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_r <= 1'b0;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
        end else if (wr_go) begin
            w_held_r <= 1'b0;
        end
    end

    // byte lanes not strobed write as zero: no effect on set/clear bits
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
            assign wr_data[gi*8 +: 8] = wstrb_r[gi] ? wdata_r[gi*8 +: 8]
                                                    : 8'h00;
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= `EPSVB_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r <= (wr_ics || wr_vto) ? `EPSVB_RESP_OKAY
                                          : `EPSVB_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    property p_unpriv_write;
        @(posedge aclk) disable iff (!aresetn)
        (wr_go && !awpriv_r) |=> s_axi_bvalid &&
            s_axi_bresp == `EPSVB_RESP_SLVERR;
    endproperty
    a_unpriv_write: assert property (p_unpriv_write)
        else $error("unprivileged write accepted");

    ////////////////////////////////////////////////////////////////////////
    // pending bits
    logic nmi_pend_r;
    logic ds_pend_r;
    logic st_pend_r;
    logic [31:9] tbl_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nmi_pend_r <= 1'b0;
        end else if (nmi_request || (wr_ics && wr_data[`EPSVB_NMI_SET_BIT]))
        begin
            nmi_pend_r <= 1'b1;
        end else if (nmi_handler_entry) begin
            nmi_pend_r <= 1'b0;
        end
    end

    // set wins over clear; only software sets this one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ds_pend_r <= 1'b0;
        end else if (wr_ics && wr_data[`EPSVB_DS_SET_BIT]) begin
            ds_pend_r <= 1'b1;
        end else if ((wr_ics && wr_data[`EPSVB_DS_CLR_BIT]) ||
                     ds_handler_entry) begin
            ds_pend_r <= 1'b0;
        end
    end

    property p_ds_hold;
        @(posedge aclk) disable iff (!aresetn)
        (!ds_pend_r && !wr_ics) |=> !ds_pend_r;
    endproperty
    a_ds_hold: assert property (p_ds_hold)
        else $error("ds pended with no write");

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_pend_r <= 1'b0;
        end else if (system_tick_exception_request ||
                     (wr_ics && wr_data[`EPSVB_ST_SET_BIT])) begin
            st_pend_r <= 1'b1;
        end else if ((wr_ics && wr_data[`EPSVB_ST_CLR_BIT]) ||
                     st_handler_entry) begin
            st_pend_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tbl_r <= 23'(`EPSVB_VTO_RESET >> `EPSVB_TBL_LO);
        end else if (wr_vto) begin
            tbl_r <= wr_data[`EPSVB_TBL_HI:`EPSVB_TBL_LO];
        end
    end

    assign pend_state.nmi_pend = nmi_pend_r;
    assign pend_state.ds_pend = ds_pend_r;
    assign pend_state.st_pend = st_pend_r;
    assign vector_table_base = {tbl_r, 9'h000};

    property p_vto_align;
        @(posedge aclk) disable iff (!aresetn)
        vector_table_base[8:0] == 9'h000;
    endproperty
    a_vto_align: assert property (p_vto_align)
        else $error("vector base low bits set");

    property p_vto_hold;
        @(posedge aclk) disable iff (!aresetn)
        !wr_vto |=> $stable(vector_table_base);
    endproperty
    a_vto_hold: assert property (p_vto_hold)
        else $error("vector base changed without write");

    ////////////////////////////////////////////////////////////////////////
    // read channel
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic [31:0] ics_view;

    always_comb begin
        ics_view = 32'h00000000;
        ics_view[`EPSVB_NMI_SET_BIT] = nmi_pend_r;
        ics_view[`EPSVB_DS_SET_BIT] = ds_pend_r;
        ics_view[`EPSVB_ST_SET_BIT] = st_pend_r;
        ics_view[`EPSVB_DEBUG_BIT] = 1'b0;
        // fed from the core's own priority logic
        ics_view[`EPSVB_IRQ_PEND_BIT] = core_status.interrupt_pending_flag;
        ics_view[`EPSVB_PEND_HI:`EPSVB_PEND_LO] =
            core_status.highest_pending_number;
        ics_view[`EPSVB_NOPRE_BIT] = core_status.no_preempted_active;
        ics_view[`EPSVB_ACT_HI:`EPSVB_ACT_LO] =
            core_status.active_exception_number;
    end

    assign s_axi_arready = !rvalid_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= `EPSVB_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_r <= 1'b1;
            if (s_axi_arprot[0] &&
                {s_axi_araddr[31:2], 2'h0} == `EPSVB_ICS_ADDR) begin
                rdata_r <= ics_view;
                rresp_r <= `EPSVB_RESP_OKAY;
            end else if (s_axi_arprot[0] &&
                         {s_axi_araddr[31:2], 2'h0} == `EPSVB_VTO_ADDR) begin
                rdata_r <= {tbl_r, 9'h000};
                rresp_r <= `EPSVB_RESP_OKAY;
            end else begin
                rdata_r <= 32'h00000000;
                rresp_r <= `EPSVB_RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    property p_read_vto;
        @(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_arprot[0] &&
         s_axi_araddr == `EPSVB_VTO_ADDR)
        |=> s_axi_rvalid && s_axi_rresp == `EPSVB_RESP_OKAY &&
            s_axi_rdata == $past(vector_table_base);
    endproperty
    a_read_vto: assert property (p_read_vto)
        else $error("vector base read mismatch");

    property p_ics_reserved;
        @(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_arprot[0] &&
         s_axi_araddr == `EPSVB_ICS_ADDR)
        |=> (s_axi_rdata & 32'h6B200600) == 32'h00000000;
    endproperty
    a_ics_reserved: assert property (p_ics_reserved)
        else $error("reserved status bits not zero");

    property p_read_status;
        @(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_arprot[0] &&
         s_axi_araddr == `EPSVB_ICS_ADDR)
        |=> s_axi_rdata[`EPSVB_PEND_HI:`EPSVB_PEND_LO] ==
            $past(core_status.highest_pending_number) &&
            s_axi_rdata[`EPSVB_IRQ_PEND_BIT] ==
            $past(core_status.interrupt_pending_flag) &&
            s_axi_rdata[`EPSVB_NOPRE_BIT] ==
            $past(core_status.no_preempted_active);
    endproperty
    a_read_status: assert property (p_read_status)
        else $error("status fields read mismatch");

    ////////////////////////////////////////////////////////////////////////
    // assertions
    property p_nmi_set;
        @(posedge aclk) disable iff (!aresetn)
        (wr_ics && wr_data[`EPSVB_NMI_SET_BIT]) |=> nmi_pend_r;
    endproperty
    a_nmi_set: assert property (p_nmi_set) else $error("nmi set lost");

    property p_nmi_clear;
        @(posedge aclk) disable iff (!aresetn)
        (nmi_handler_entry && !nmi_request && !wr_ics) |=> !nmi_pend_r;
    endproperty
    a_nmi_clear: assert property (p_nmi_clear)
        else $error("nmi not cleared on entry");

    property p_nmi_hold;
        @(posedge aclk) disable iff (!aresetn)
        (!nmi_pend_r && !nmi_request && !wr_ics) |=> !nmi_pend_r;
    endproperty
    a_nmi_hold: assert property (p_nmi_hold)
        else $error("nmi pended with no cause");

    property p_ds_set;
        @(posedge aclk) disable iff (!aresetn)
        (wr_ics && wr_data[`EPSVB_DS_SET_BIT]) |=> ds_pend_r;
    endproperty
    a_ds_set: assert property (p_ds_set) else $error("ds set lost");

    property p_ds_only_sw;
        @(posedge aclk) disable iff (!aresetn)
        $rose(ds_pend_r) |-> $past(wr_ics && wr_data[`EPSVB_DS_SET_BIT]);
    endproperty
    a_ds_only_sw: assert property (p_ds_only_sw)
        else $error("ds pended by hardware");

    property p_ds_clr;
        @(posedge aclk) disable iff (!aresetn)
        (wr_ics && wr_data[`EPSVB_DS_CLR_BIT] && !wr_data[`EPSVB_DS_SET_BIT])
        |=> !ds_pend_r;
    endproperty
    a_ds_clr: assert property (p_ds_clr) else $error("ds clear lost");

    property p_st_set;
        @(posedge aclk) disable iff (!aresetn)
        (wr_ics && wr_data[`EPSVB_ST_SET_BIT]) |=> st_pend_r;
    endproperty
    a_st_set: assert property (p_st_set) else $error("st set lost");

    property p_st_clr;
        @(posedge aclk) disable iff (!aresetn)
        (wr_ics && wr_data[`EPSVB_ST_CLR_BIT] && !wr_data[`EPSVB_ST_SET_BIT]
         && !system_tick_exception_request) |=> !st_pend_r;
    endproperty
    a_st_clr: assert property (p_st_clr) else $error("st clear lost");

    property p_read_ics;
        @(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_arprot[0] &&
         s_axi_araddr == `EPSVB_ICS_ADDR)
        |=> s_axi_rvalid && s_axi_rdata[`EPSVB_ACT_HI:`EPSVB_ACT_LO] ==
            $past(core_status.active_exception_number) &&
            s_axi_rdata[`EPSVB_DEBUG_BIT] == 1'b0;
    endproperty
    a_read_ics: assert property (p_read_ics)
        else $error("status read mismatch");

    property p_vto;
        @(posedge aclk) disable iff (!aresetn)
        wr_vto |=> vector_table_base ==
            {$past(wr_data[`EPSVB_TBL_HI:`EPSVB_TBL_LO]), 9'h000};
    endproperty
    a_vto: assert property (p_vto) else $error("vector base wrong");

endmodule
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench of the exception pend block over axi4-lite
`timescale 1ns/1ns
`default_nettype none
`include "epsvb_regs.svh"
module tb_top;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
    logic [2:0] awprot = 3'h0, arprot = 3'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [4:0] ev = 5'h00;
    epsvb_pkg::epsvb_core_type cs = '0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rsp;
    logic [31:0] rdata, vtb, rd;
    epsvb_pkg::epsvb_pend_type ps;
    int bad_count = 0, samples_checked = 0, cyc = 0;
    logic [31:0] ics = `EPSVB_ICS_ADDR;
    logic [31:0] vto = `EPSVB_VTO_ADDR;

    epsvb_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(awprot), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(arprot), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .core_status(cs),
        .nmi_request(ev[0]), .system_tick_exception_request(ev[1]),
        .nmi_handler_entry(ev[2]), .ds_handler_entry(ev[3]),
        .st_handler_entry(ev[4]), .pend_state(ps), .vector_table_base(vtb));

    ////////////////////////////////////////////////////////////////////////
    initial begin
        forever #10 aclk = ~aclk;
    end

    initial begin
        forever begin
            @(posedge aclk);
            cyc++;
            if (cyc > 5000) begin
                bad_count++;
                give_verdict();
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [31:0] a, d, input logic [2:0] p);
        logic aw_go, w_go, b_go;
        @(posedge aclk);
        awaddr <= a;
        awprot <= p;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        b_go = 1'b0;
        while (!b_go) begin
            @(negedge aclk);
            aw_go = awvalid && awready;
            w_go = wvalid && wready;
            b_go = bvalid;
            rsp = bresp;
            @(posedge aclk);
            if (aw_go) awvalid <= 1'b0;
            if (w_go) wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [2:0] p,
                          input logic [31:0] exp, input logic [1:0] er);
        logic ar_go, r_go;
        @(posedge aclk);
        araddr <= a;
        arprot <= p;
        arvalid <= 1'b1;
        rready <= 1'b1;
        r_go = 1'b0;
        while (!r_go) begin
            @(negedge aclk);
            ar_go = arvalid && arready;
            r_go = rvalid;
            rd = rdata;
            rsp = rresp;
            @(posedge aclk);
            if (ar_go) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        chk("rdata", exp, rd);
        chk("rresp", {30'h0, er}, {30'h0, rsp});
    endtask

    task automatic pulse(input int i);
        @(posedge aclk);
        ev[i] <= 1'b1;
        @(posedge aclk);
        ev <= 5'h00;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        int sb[2] = '{28, 26};
        int en[2] = '{3, 4};
        logic [31:0] sv;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(ics, 3'h1, 32'h0, 2'h0);
        rd_chk(vto, 3'h1, 32'h0, 2'h0);
        $display("test reset done");
        wr(ics, 32'h0, 3'h1);
        rd_chk(ics, 3'h1, 32'h0, 2'h0);
        wr(ics, 32'h80000000, 3'h1);
        chk("bresp", 32'h0, {30'h0, rsp});
        rd_chk(ics, 3'h1, 32'h80000000, 2'h0);
        pulse(2);
        rd_chk(ics, 3'h1, 32'h0, 2'h0);
        pulse(0);
        rd_chk(ics, 3'h1, 32'h80000000, 2'h0);
        pulse(2);
        $display("test nonmaskable done");
        for (int i = 0; i < 2; i++) begin
            sv = 32'h1 << sb[i];
            wr(ics, sv, 3'h1);
            rd_chk(ics, 3'h1, sv, 2'h0);
            chk("pend_state", 32'h2 >> i, {29'h0, ps});
            wr(ics, sv >> 1, 3'h1);
            rd_chk(ics, 3'h1, 32'h0, 2'h0);
            wr(ics, sv, 3'h1);
            pulse(en[i]);
            rd_chk(ics, 3'h1, 32'h0, 2'h0);
        end
        pulse(0);
        pulse(1);
        rd_chk(ics, 3'h1, 32'h84000000, 2'h0);
        chk("pend_state", 32'h5, {29'h0, ps});
        wr(ics, 32'h02000000, 3'h1);
        pulse(2);
        $display("test pending done");
        cs <= {9'h025, 1'b1, 9'h013, 1'b1, 1'b1};
        rd_chk(ics, 3'h1, 32'h00413825, 2'h0);
        cs <= {9'h003, 1'b0, 9'h000, 1'b0, 1'b0};
        rd_chk(ics, 3'h1, 32'h00000003, 2'h0);
        cs <= '0;
        wr(ics, 32'h61A00600, 3'h1);
        rd_chk(ics, 3'h1, 32'h0, 2'h0);
        $display("test status done");
        wr(vto, 32'hFFFFFFFF, 3'h1);
        rd_chk(vto, 3'h1, 32'hFFFFFE00, 2'h0);
        wr(vto, 32'h12345680, 3'h1);
        rd_chk(vto, 3'h1, 32'h12345600, 2'h0);
        chk("vector_table_base", 32'h12345600, vtb);
        $display("test vector base done");
        wr(32'hE000ED0C, 32'hFFFFFFFF, 3'h1);
        chk("bresp", 32'h2, {30'h0, rsp});
        rd_chk(32'hE000ED0C, 3'h1, 32'h0, 2'h2);
        wr(vto, 32'h0, 3'h0);
        chk("bresp", 32'h2, {30'h0, rsp});
        rd_chk(vto, 3'h0, 32'h0, 2'h2);
        rd_chk(vto, 3'h1, 32'h12345600, 2'h0);
        $display("test access errors done");
        give_verdict();
    end
endmodule
`default_nettype wire
